// [src/hbx_pkg.sv]
// hbx_pkg: shared types and constants of the exception priority and recovery unit
// assumes a single core clock domain and a head-first view of the history buffer
package hbx_pkg;

  // ===========================================================================
  // history buffer
  // ===========================================================================
  localparam int HBX_HB_DEPTH = 6;

  // one history buffer entry as seen from the exception unit
  typedef struct packed {
    logic valid;      // entry holds an issued instruction
    logic wb_done;    // writeback stage completed
    logic fault;      // instruction raised its own exception
    logic finish_ok;  // special/state write, return, cache op or bus access in flight
  } hbx_entry_s;

  // ===========================================================================
  // special register numbers
  // ===========================================================================
  localparam int HBX_SPR_W = 10;
  localparam logic [HBX_SPR_W-1:0] HBX_SPR_IRQ_ENABLE_RECOVERABLE = 10'h050;
  localparam logic [HBX_SPR_W-1:0] HBX_SPR_IRQ_DISABLE_RECOVERABLE = 10'h051;
  localparam logic [HBX_SPR_W-1:0] HBX_SPR_IRQ_DISABLE_UNRECOVERABLE = 10'h052;

  typedef enum logic [1:0] {
    HBX_PSPR_NONE,
    HBX_PSPR_EIE_CMD,
    HBX_PSPR_EID_CMD,
    HBX_PSPR_NRI_CMD
  } hbx_pspr_e;

  // ===========================================================================
  // machine state register, low half (architectural bits 16..31)
  // ===========================================================================
  localparam int HBX_HALF_W = 16;
  localparam int HBX_WORD_W = 32;
  localparam int HBX_EE_POS = 15;  // architectural bit 16
  localparam int HBX_RI_POS = 1;   // architectural bit 30
  localparam logic [HBX_HALF_W-1:0] HBX_MSR_RESET = 16'h0000;
  localparam logic [HBX_WORD_W-1:0] HBX_SSR_RESET = 32'h0000_0000;

  // ===========================================================================
  // exception causes, highest priority first
  // ===========================================================================
  typedef enum logic [2:0] {
    HBX_CAUSE_NONE,
    HBX_CAUSE_NM_BREAK,
    HBX_CAUSE_RESET,
    HBX_CAUSE_SYNC,
    HBX_CAUSE_M_BREAK,
    HBX_CAUSE_EXT_IRQ,
    HBX_CAUSE_DECR
  } hbx_cause_e;

  localparam int HBX_INFO_PAD_W = HBX_HALF_W - 3;
  localparam logic [HBX_INFO_PAD_W-1:0] HBX_INFO_PAD = 13'h0000;

  // requests offered to the arbiter
  typedef struct packed {
    logic nm_break;
    logic reset_exc;
    logic sync_head;
    logic m_break;
    logic ext_irq;
    logic decr;
  } hbx_req_s;

endpackage : hbx_pkg

// [src/hbx_prio.sv]
// hbx_prio: fixed priority pick among pending exception requests
// assumes requests are already gated by their enables
`timescale 1ns/10ps
module hbx_prio
  import hbx_pkg::*;
(
  input hbx_req_s req,
  output hbx_cause_e cause
);

  // ===========================================================================
  // priority chain
  // ===========================================================================
  always_comb begin
    if (req.nm_break) begin
      cause = HBX_CAUSE_NM_BREAK; // RQ14
    end else if (req.reset_exc) begin
      cause = HBX_CAUSE_RESET; // RQ15
    end else if (req.sync_head) begin
      cause = HBX_CAUSE_SYNC; // RQ16
    end else if (req.m_break) begin
      cause = HBX_CAUSE_M_BREAK; // RQ18
    end else if (req.ext_irq) begin
      cause = HBX_CAUSE_EXT_IRQ; // RQ19
    end else if (req.decr) begin
      cause = HBX_CAUSE_DECR; // RQ20
    end else begin
      cause = HBX_CAUSE_NONE;
    end
  end

endmodule : hbx_prio

// [src/hbx_exc_unit.sv]
// hbx_exc_unit: exception arbitration, async retirement and flush, recovery bits
// assumes the pipeline presents the history buffer head first and drops
// retired or flushed entries within one cycle of the pulse
`timescale 1ns/10ps
//
// Contract
// RQ1: async exception retires completed fault-free prefix
// RQ2: exception attaches to oldest remaining head entry
// RQ3: finish-type head retires, exception moves onward
// RQ4: head's own fault is serviced first
// RQ5: other head types flushed with all younger
// RQ6: taking exception clears external interrupt enable
// RQ7: recoverable bit saved, then cleared
// RQ8: unordered exceptions recoverable unless saving state
// RQ9: handler sets recoverable after prologue, clears before epilogue
// RQ10: handler avoids faults around register save/restore
// RQ11: writes to 80/81/82 set enable/recoverable combos
// RQ12: reads of 80/81/82 raise software emulation
// RQ13: non-maskable async outrank all, taken immediately
// RQ14: non-maskable breakpoint priority 1, immediate
// RQ15: reset exception priority 2, immediate
// RQ16: synchronous faults priority 3, program order
// RQ17: maskable async wait for head's exceptions
// RQ18: maskable breakpoint priority 4, retire then flush
// RQ19: external interrupt priority 5, held while disabled
// RQ20: decrementer priority 6, held while disabled
// RQ21: critical masked code keeps recoverable bit set
// RQ22: status save gets info high, state low
// RQ23: enable clear defers interrupt and decrementer
module hbx_exc_unit
  import hbx_pkg::*;
#(
  parameter int HB_DEPTH = HBX_HB_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input hbx_entry_s [HB_DEPTH-1:0] hb_entry,
  input wire logic nm_break_req,
  input wire logic reset_exc_req,
  input wire logic m_break_req,
  input wire logic ext_irq_req,
  input wire logic decr_event,
  input wire logic spr_wr_valid,
  input wire logic spr_rd_valid,
  input wire logic [HBX_SPR_W-1:0] spr_num,
  input wire logic msr_wr_valid,
  input wire logic [HBX_HALF_W-1:0] msr_wr_data,
  input wire logic rfi_valid,
  output logic [HB_DEPTH-1:0] hb_retire,
  output logic [HB_DEPTH-1:0] hb_flush,
  output logic exc_take,
  output hbx_cause_e exc_cause,
  output logic [$clog2(HB_DEPTH+1)-1:0] exc_slot,
  output logic sw_emul_exc,
  output logic [HBX_HALF_W-1:0] machine_state_reg,
  output logic [HBX_WORD_W-1:0] status_save_reg,
  output logic ext_irq_enable_bit,
  output logic recoverable_bit
);

  localparam int SLOT_W = $clog2(HB_DEPTH + 1);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT_HEAD,
    ST_SETTLE
  } hbx_state_e;

  // ===========================================================================
  // helpers
  // ===========================================================================
  function automatic hbx_pspr_e pspr_decode(input logic [HBX_SPR_W-1:0] num);
    hbx_pspr_e res;
    res = HBX_PSPR_NONE;
    case (num)
      HBX_SPR_IRQ_ENABLE_RECOVERABLE: begin
        res = HBX_PSPR_EIE_CMD;
      end
      HBX_SPR_IRQ_DISABLE_RECOVERABLE: begin
        res = HBX_PSPR_EID_CMD;
      end
      HBX_SPR_IRQ_DISABLE_UNRECOVERABLE: begin
        res = HBX_PSPR_NRI_CMD;
      end
      default: begin
        res = HBX_PSPR_NONE;
      end
    endcase
    return res;
  endfunction : pspr_decode

  function automatic logic entry_clean(input hbx_entry_s e);
    return e.valid & e.wb_done & ~e.fault;
  endfunction : entry_clean

  function automatic logic is_async_maskable(input hbx_cause_e c);
    return (c == HBX_CAUSE_M_BREAK) || (c == HBX_CAUSE_EXT_IRQ) || (c == HBX_CAUSE_DECR);
  endfunction : is_async_maskable

  // ===========================================================================
  // state
  // ===========================================================================
  hbx_state_e state_reg;
  hbx_state_e state_next;
  logic decr_pend_reg;
  logic [HBX_HALF_W-1:0] msr_reg;
  logic [HBX_WORD_W-1:0] ssr_reg;
  logic [HB_DEPTH-1:0] retire_reg;
  logic [HB_DEPTH-1:0] flush_reg;
  logic take_reg;
  hbx_cause_e cause_reg;
  logic [SLOT_W-1:0] slot_reg;
  logic emul_reg;

  // ===========================================================================
  // retirement prefix and head search
  // ===========================================================================
  logic [HB_DEPTH-1:0] prefix_mask;
  logic [HB_DEPTH-1:0] valid_mask;
  logic [HB_DEPTH-1:0] from_head_mask;
  logic [SLOT_W-1:0] head_idx;
  hbx_entry_s head_ent;
  logic head_vld;

  always_comb begin
    logic run;
    run = 1'b1;
    head_idx = SLOT_W'(HB_DEPTH);
    head_ent = '0;
    for (int i = 0; i < HB_DEPTH; i++) begin
      valid_mask[i] = hb_entry[i].valid;
      prefix_mask[i] = run & entry_clean(hb_entry[i]); // RQ1
      if (run && !entry_clean(hb_entry[i])) begin
        head_idx = SLOT_W'(i); // RQ2
        head_ent = hb_entry[i];
      end
      run = run & entry_clean(hb_entry[i]);
    end
    head_vld = head_ent.valid;
    from_head_mask = valid_mask & ~prefix_mask;
  end

  // ===========================================================================
  // arbitration
  // ===========================================================================
  hbx_req_s req;
  hbx_cause_e pick;
  logic ee;
  logic ri;

  assign ee = msr_reg[HBX_EE_POS];
  assign ri = msr_reg[HBX_RI_POS];

  always_comb begin
    req.nm_break = nm_break_req; // RQ13
    req.reset_exc = reset_exc_req; // RQ13
    req.sync_head = head_vld & head_ent.wb_done & head_ent.fault; // RQ4 RQ17
    req.m_break = m_break_req;
    req.ext_irq = ext_irq_req & ee; // RQ19 RQ23
    req.decr = decr_pend_reg & ee; // RQ20 RQ23
  end

  hbx_prio u_prio (
    .req(req),
    .cause(pick)
  );

  // ===========================================================================
  // sequencing decision
  // ===========================================================================
  logic do_take;
  logic [HB_DEPTH-1:0] retire_next;
  logic [HB_DEPTH-1:0] flush_next;
  logic [SLOT_W-1:0] slot_next;

  always_comb begin
    do_take = 1'b0;
    retire_next = '0;
    flush_next = '0;
    slot_next = head_idx;
    state_next = state_reg;
    case (state_reg)
      ST_RUN, ST_WAIT_HEAD: begin
        if (pick == HBX_CAUSE_NM_BREAK || pick == HBX_CAUSE_RESET) begin
          do_take = 1'b1; // RQ13
          flush_next = valid_mask; // RQ14 RQ15
          slot_next = '0;
          state_next = ST_SETTLE;
        end else if (pick == HBX_CAUSE_SYNC) begin
          do_take = 1'b1; // RQ16
          retire_next = prefix_mask;
          flush_next = from_head_mask;
          state_next = ST_SETTLE;
        end else if (is_async_maskable(pick)) begin
          retire_next = prefix_mask; // RQ1 RQ18
          if (head_vld && head_ent.finish_ok) begin
            state_next = ST_SETTLE; // RQ3
          end else begin
            do_take = 1'b1; // RQ2
            flush_next = from_head_mask; // RQ5
            state_next = ST_SETTLE;
          end
        end else begin
          state_next = ST_RUN;
        end
        if (is_async_maskable(pick) && head_vld && head_ent.finish_ok) begin
          state_next = (|prefix_mask) ? ST_SETTLE : ST_WAIT_HEAD; // RQ3
        end
      end
      ST_SETTLE: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // ===========================================================================
  // outputs toward the history buffer
  // ===========================================================================
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      retire_reg <= '0;
      flush_reg <= '0;
      take_reg <= 1'b0;
      cause_reg <= HBX_CAUSE_NONE;
      slot_reg <= '0;
    end else begin
      retire_reg <= retire_next;
      flush_reg <= flush_next;
      take_reg <= do_take;
      cause_reg <= do_take ? pick : HBX_CAUSE_NONE;
      slot_reg <= do_take ? slot_next : '0;
    end
  end

  // ===========================================================================
  // decrementer event, held until taken
  // ===========================================================================
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      decr_pend_reg <= 1'b0;
    end else if (decr_event) begin
      decr_pend_reg <= 1'b1; // RQ20
    end else if (do_take && pick == HBX_CAUSE_DECR) begin
      decr_pend_reg <= 1'b0;
    end
  end

  // ===========================================================================
  // machine state low half
  // ===========================================================================
  hbx_pspr_e wr_cmd;
  assign wr_cmd = spr_wr_valid ? pspr_decode(spr_num) : HBX_PSPR_NONE;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      msr_reg <= HBX_MSR_RESET;
    end else if (do_take) begin
      msr_reg[HBX_EE_POS] <= 1'b0; // RQ6
      msr_reg[HBX_RI_POS] <= 1'b0; // RQ7
    end else if (rfi_valid) begin
      msr_reg <= ssr_reg[HBX_HALF_W-1:0];
    end else if (msr_wr_valid) begin
      msr_reg <= msr_wr_data;
    end else begin
      case (wr_cmd)
        HBX_PSPR_EIE_CMD: begin
          msr_reg[HBX_EE_POS] <= 1'b1; // RQ11
          msr_reg[HBX_RI_POS] <= 1'b1; // RQ11
        end
        HBX_PSPR_EID_CMD: begin
          msr_reg[HBX_EE_POS] <= 1'b0; // RQ11
          msr_reg[HBX_RI_POS] <= 1'b1; // RQ11
        end
        HBX_PSPR_NRI_CMD: begin
          msr_reg[HBX_EE_POS] <= 1'b0; // RQ11
          msr_reg[HBX_RI_POS] <= 1'b0; // RQ11
        end
        default: begin
          msr_reg <= msr_reg;
        end
      endcase
    end
  end

  // ===========================================================================
  // status save register
  // ===========================================================================
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ssr_reg <= HBX_SSR_RESET;
    end else if (do_take) begin
      ssr_reg <= {HBX_INFO_PAD, pick, msr_reg}; // RQ22 RQ7 RQ8
    end
  end

  // ===========================================================================
  // pseudo register reads trap to emulation
  // ===========================================================================
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      emul_reg <= 1'b0;
    end else begin
      emul_reg <= spr_rd_valid && (pspr_decode(spr_num) != HBX_PSPR_NONE); // RQ12
    end
  end

  assign hb_retire = retire_reg;
  assign hb_flush = flush_reg;
  assign exc_take = take_reg;
  assign exc_cause = cause_reg;
  assign exc_slot = slot_reg;
  assign sw_emul_exc = emul_reg;
  assign machine_state_reg = msr_reg;
  assign status_save_reg = ssr_reg;
  assign ext_irq_enable_bit = msr_reg[HBX_EE_POS];
  assign recoverable_bit = msr_reg[HBX_RI_POS];

endmodule : hbx_exc_unit

// [bench/hbx_exc_chk.sv]
// hbx_exc_chk: port assertions of the exception unit
// assumes bind onto hbx_exc_unit, single core clock
`timescale 1ns/10ps
module hbx_exc_chk
  import hbx_pkg::*;
#(
  parameter int HB_DEPTH = HBX_HB_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input hbx_entry_s [HB_DEPTH-1:0] hb_entry,
  input wire logic nm_break_req,
  input wire logic reset_exc_req,
  input wire logic m_break_req,
  input wire logic ext_irq_req,
  input wire logic spr_wr_valid,
  input wire logic spr_rd_valid,
  input wire logic [HBX_SPR_W-1:0] spr_num,
  input wire logic msr_wr_valid,
  input wire logic rfi_valid,
  input wire logic [HB_DEPTH-1:0] hb_retire,
  input wire logic [HB_DEPTH-1:0] hb_flush,
  input wire logic exc_take,
  input hbx_cause_e exc_cause,
  input wire logic [$clog2(HB_DEPTH+1)-1:0] exc_slot,
  input wire logic sw_emul_exc,
  input wire logic [HBX_HALF_W-1:0] machine_state_reg,
  input wire logic [HBX_WORD_W-1:0] status_save_reg,
  input wire logic ext_irq_enable_bit,
  input wire logic recoverable_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // exception requests at the edge after a retire or take are ignored by the unit
  logic busy;
  assign busy = exc_take || (|hb_retire);
  sequence irq_head_s;
    !busy && !nm_break_req && !reset_exc_req && !m_break_req && ext_irq_req && ext_irq_enable_bit
      && hb_entry[0].valid && !hb_entry[0].wb_done && !hb_entry[0].finish_ok;
  endsequence
  sequence irq_flush_s;
    exc_take && exc_cause == HBX_CAUSE_EXT_IRQ && hb_flush[0] && exc_slot == 0 ##1 !exc_take && hb_retire == '0;
  endsequence
  nm_first_a: assert property (nm_break_req && !busy |=> exc_take && exc_cause == HBX_CAUSE_NM_BREAK
    && exc_slot == 0 && hb_retire == '0) else $error("non-maskable break not taken first");
  reset_second_a: assert property (reset_exc_req && !nm_break_req && !busy |=> exc_take
    && exc_cause == HBX_CAUSE_RESET) else $error("reset exception not taken");
  take_masks_a: assert property (exc_take |-> !ext_irq_enable_bit && !recoverable_bit)
    else $error("enable or recoverable left set on take");
  state_saved_a: assert property (exc_take |-> status_save_reg[HBX_HALF_W-1:0] == $past(machine_state_reg)
    && status_save_reg[HBX_WORD_W-1:HBX_HALF_W] == 16'(exc_cause)) else $error("status save wrong");
  irq_gate_a: assert property (exc_take && (exc_cause == HBX_CAUSE_EXT_IRQ || exc_cause == HBX_CAUSE_DECR)
    |-> $past(ext_irq_enable_bit)) else $error("masked interrupt taken");
  prefix_only_a: assert property (((hb_retire + 1'b1) & hb_retire) == '0 && (hb_retire & hb_flush) == '0)
    else $error("retire mask not a clean prefix");
  flush_take_a: assert property (|hb_flush |-> exc_take) else $error("flush without take");
  irq_walk_a: assert property (irq_head_s |=> irq_flush_s) else $error("head not flushed for irq");
  eie_cmd_a: assert property (spr_wr_valid && spr_num == HBX_SPR_IRQ_ENABLE_RECOVERABLE && !busy
    && !rfi_valid && !msr_wr_valid |=> exc_take || (ext_irq_enable_bit && recoverable_bit))
    else $error("enable command lost");
  nri_cmd_a: assert property (spr_wr_valid && spr_num == HBX_SPR_IRQ_DISABLE_UNRECOVERABLE
    |=> !ext_irq_enable_bit && !recoverable_bit) else $error("disable command lost");
  emul_read_a: assert property (spr_rd_valid && spr_num >= HBX_SPR_IRQ_ENABLE_RECOVERABLE
    && spr_num <= HBX_SPR_IRQ_DISABLE_UNRECOVERABLE |=> sw_emul_exc) else $error("pseudo read not refused");
endmodule : hbx_exc_chk

bind hbx_exc_unit hbx_exc_chk #(.HB_DEPTH(HB_DEPTH)) u_chk (.*);

// [bench/hbx_hb_model.sv]
// hbx_hb_model: history buffer side of the pipeline
// assumes retire and flush masks are one-cycle pulses
`timescale 1ns/10ps
module hbx_hb_model
  import hbx_pkg::*;
#(
  parameter int HB_DEPTH = HBX_HB_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic load,
  input hbx_entry_s [HB_DEPTH-1:0] load_entry,
  input wire logic [HB_DEPTH-1:0] hb_retire,
  input wire logic [HB_DEPTH-1:0] hb_flush,
  output hbx_entry_s [HB_DEPTH-1:0] hb_entry
);
  typedef hbx_entry_s [HB_DEPTH-1:0] hbx_hb_t;
  function automatic hbx_hb_t drop(input hbx_hb_t q, input logic [HB_DEPTH-1:0] gone);
    hbx_hb_t r;
    int k;
    r = '0;
    k = 0;
    for (int i = 0; i < HB_DEPTH; i++) begin
      if (!gone[i]) begin
        r[k] = q[i];
        k++;
      end
    end
    return r;
  endfunction : drop
  // departed entries vanish, survivors slide to the head
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hb_entry <= '0;
    end else if (load) begin
      hb_entry <= load_entry;
    end else begin
      hb_entry <= drop(hb_entry, hb_retire | hb_flush);
    end
  end
endmodule : hbx_hb_model

// [bench/tb.sv]
// tb: self-checking bench of the exception unit
// assumes the history buffer model as pipeline, entry nibble {valid,done,fault,finish}
`timescale 1ns/10ps
module tb
  import hbx_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic load = 1'b0;
  hbx_entry_s [5:0] load_entry = '0;
  hbx_entry_s [5:0] hb_entry;
  logic nm_break_req = 1'b0;
  logic reset_exc_req = 1'b0;
  logic m_break_req = 1'b0;
  logic ext_irq_req = 1'b0;
  logic decr_event = 1'b0;
  logic spr_wr_valid = 1'b0;
  logic spr_rd_valid = 1'b0;
  logic [9:0] spr_num = '0;
  logic msr_wr_valid = 1'b0;
  logic [15:0] msr_wr_data = '0;
  logic rfi_valid = 1'b0;
  logic [5:0] hb_retire;
  logic [5:0] hb_flush;
  logic exc_take;
  hbx_cause_e exc_cause;
  logic [2:0] exc_slot;
  logic sw_emul_exc;
  logic [15:0] machine_state_reg;
  logic [31:0] status_save_reg;
  logic ext_irq_enable_bit;
  logic recoverable_bit;
  int mismatches = 0;
  int checked = 0;

  always #12.5 ref_clk = ~ref_clk;

  hbx_exc_unit #(.HB_DEPTH(6)) DUT (.ref_clk, .reset_n, .hb_entry, .nm_break_req, .reset_exc_req,
    .m_break_req, .ext_irq_req, .decr_event, .spr_wr_valid, .spr_rd_valid, .spr_num, .msr_wr_valid,
    .msr_wr_data, .rfi_valid, .hb_retire, .hb_flush, .exc_take, .exc_cause, .exc_slot, .sw_emul_exc,
    .machine_state_reg, .status_save_reg, .ext_irq_enable_bit, .recoverable_bit);
  hbx_hb_model #(.HB_DEPTH(6)) u_hb (.ref_clk, .reset_n, .load, .load_entry, .hb_retire, .hb_flush,
    .hb_entry);

  // ===========================================================================
  // helpers
  // ===========================================================================
  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic hb(input logic [23:0] v);
    load = 1'b1;
    load_entry = v;
    step();
    load = 1'b0;
  endtask : hb

  task automatic spr(input logic wr, input logic [9:0] n, input logic last);
    spr_wr_valid = wr;
    spr_rd_valid = !wr;
    spr_num = n;
    step();
    if (last) begin
      spr_wr_valid = 1'b0;
      spr_rd_valid = 1'b0;
    end
  endtask : spr

  task automatic take(input hbx_cause_e c, input logic [2:0] s, input logic [5:0] r, input logic [5:0] f);
    int n;
    n = 0;
    while (exc_take !== 1'b1 && n < 12) begin
      step();
      n++;
    end
    {nm_break_req, reset_exc_req, m_break_req} = '0;
    chk("take", 1, exc_take);
    chk("cause", c, exc_cause);
    chk("slot", s, exc_slot);
    chk("retire", r, hb_retire);
    chk("flush", f, hb_flush);
  endtask : take

  // ===========================================================================
  // scenarios
  // ===========================================================================
  task automatic t_spr();
    for (int i = 0; i < 3; i++) begin
      spr(1'b1, 10'(HBX_SPR_IRQ_ENABLE_RECOVERABLE + i), 1'b0);
      chk("ee_ri", {i == 0, i != 2}, {ext_irq_enable_bit, recoverable_bit});
    end
    for (int i = 0; i < 4; i++) begin
      spr(1'b0, 10'(HBX_SPR_IRQ_ENABLE_RECOVERABLE + i), 1'b0);
      chk("emul", i < 3, sw_emul_exc);
    end
    spr(1'b1, HBX_SPR_IRQ_ENABLE_RECOVERABLE, 1'b1);
    chk("msr", 16'h8002, machine_state_reg);
  endtask : t_spr

  task automatic t_async();
    hb(24'h0088cc);
    ext_irq_req = 1'b1;
    take(HBX_CAUSE_EXT_IRQ, 3'd2, 6'h03, 6'h0c);
    chk("ssr", 32'h0005_8002, status_save_reg);
    chk("ee_ri", 0, {ext_irq_enable_bit, recoverable_bit});
  endtask : t_async

  task automatic t_masked();
    decr_event = 1'b1;
    step();
    decr_event = 1'b0;
    hb(24'h000008);
    repeat (6) begin
      step();
      chk("held", 0, exc_take);
    end
    spr(1'b1, HBX_SPR_IRQ_ENABLE_RECOVERABLE, 1'b1);
    take(HBX_CAUSE_EXT_IRQ, 3'd0, 6'h00, 6'h01);
    ext_irq_req = 1'b0;
    step();
    spr(1'b1, HBX_SPR_IRQ_ENABLE_RECOVERABLE, 1'b1);
    // empty buffer: the head is the first free slot
    take(HBX_CAUSE_DECR, 3'd0, 6'h00, 6'h00);
  endtask : t_masked

  task automatic t_finish();
    hb(24'h000089);
    m_break_req = 1'b1;
    repeat (4) begin
      step();
      chk("wait", 0, exc_take);
    end
    hb(24'h00008d);
    take(HBX_CAUSE_M_BREAK, 3'd1, 6'h01, 6'h02);
  endtask : t_finish

  task automatic t_headfault();
    hb(24'h000889);
    m_break_req = 1'b1;
    step();
    hb(24'h00088f);
    take(HBX_CAUSE_SYNC, 3'd0, 6'h00, 6'h07);
  endtask : t_headfault

  task automatic t_sync();
    spr(1'b1, HBX_SPR_IRQ_ENABLE_RECOVERABLE, 1'b1);
    // a faulting entry sits right behind the two-entry clean prefix
    hb(24'h008ecc);
    ext_irq_req = 1'b1;
    take(HBX_CAUSE_SYNC, 3'd2, 6'h03, 6'h0c);
    ext_irq_req = 1'b0;
    step();
  endtask : t_sync

  task automatic t_nonmask();
    spr(1'b1, HBX_SPR_IRQ_DISABLE_RECOVERABLE, 1'b1);
    hb(24'h00008c);
    {nm_break_req, reset_exc_req, m_break_req, ext_irq_req} = 4'hf;
    take(HBX_CAUSE_NM_BREAK, 3'd0, 6'h00, 6'h03);
    ext_irq_req = 1'b0;
    chk("ssr_ri", 1, status_save_reg[HBX_RI_POS]);
    step();
    hb(24'h00008c);
    {reset_exc_req, m_break_req} = 2'b11;
    take(HBX_CAUSE_RESET, 3'd0, 6'h00, 6'h03);
    chk("ssr_ri", 0, status_save_reg[HBX_RI_POS]);
    step();
  endtask : t_nonmask

  task automatic t_restore();
    msr_wr_valid = 1'b1;
    msr_wr_data = 16'h0002;
    step();
    msr_wr_valid = 1'b0;
    chk("msr_wr", 16'h0002, machine_state_reg);
    rfi_valid = 1'b1;
    step();
    rfi_valid = 1'b0;
    // saved state of the last take had both bits clear
    chk("rfi", 16'h0000, machine_state_reg);
  endtask : t_restore

  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    step();
    t_spr();
    t_async();
    t_masked();
    t_finish();
    t_headfault();
    t_sync();
    t_nonmask();
    t_restore();
    end_of_test();
  end
endmodule : tb
